// ==== tb_table_write_and_indexed_add.sv ====
// Self-checking testbench for the table store and indexed add execution block
`timescale 1ns/10ps
`include "tsa_params.svh"
module tb_table_write_and_indexed_add;
	logic        mclk;
	logic        arst_n;
	logic        instr_valid;
	logic [15:0] instr;
	logic        instr_ready;
	logic        indexed_mode;
	logic [7:0]  table_byte_latch;
	logic        ptr_load;
	logic [20:0] ptr_wdata;
	logic [20:0] table_address_reg;
	logic [2:0]  hold_raddr;
	logic [7:0]  hold_rdata;
	logic        byte_sel_high;
	logic [11:0] index_base_reg;
	logic        acc_load;
	logic [7:0]  acc_wdata;
	logic [7:0]  acc;
	logic [11:0] dmem_addr;
	logic [7:0]  dmem_rdata;
	logic        dmem_we;
	logic [7:0]  dmem_wdata;
	logic        flag_neg;
	logic        flag_signed_wrap;
	logic        flag_carry;
	logic        flag_half_carry;
	logic        flag_zero;
	logic [4:0]  exp_flags;
	int          n_fail;
	int          checks;

	tsa_core dut (
		.mclk(mclk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .indexed_mode(indexed_mode),
		.table_byte_latch(table_byte_latch), .ptr_load(ptr_load), .ptr_wdata(ptr_wdata),
		.table_address_reg(table_address_reg), .hold_raddr(hold_raddr),
		.hold_rdata(hold_rdata), .byte_sel_high(byte_sel_high),
		.index_base_reg(index_base_reg), .acc_load(acc_load), .acc_wdata(acc_wdata),
		.acc(acc), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata), .dmem_we(dmem_we),
		.dmem_wdata(dmem_wdata), .flag_neg(flag_neg), .flag_signed_wrap(flag_signed_wrap),
		.flag_carry(flag_carry), .flag_half_carry(flag_half_carry), .flag_zero(flag_zero)
	);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Offer at a falling edge where the port is ready; bounded wait for the next Q1
	task automatic issue(input logic [15:0] w);
		int i;
		for (i = 0; i < 12 && instr_ready !== 1'b1; i++)
			@(negedge mclk);
		chk(instr_ready, 1'b1);
		instr = w;
		instr_valid = 1'b1;
		@(negedge mclk);
		instr_valid = 1'b0;
	endtask

	// Store with pointer variant; slot must still hold its reset value beforehand
	task automatic store(input logic [1:0] mode, input logic [20:0] p, input logic [7:0] lat,
		input logic [20:0] exp_ptr, input logic [2:0] slot);
		ptr_load = 1'b1;
		ptr_wdata = p;
		@(negedge mclk);
		ptr_load = 1'b0;
		table_byte_latch = lat;
		issue({14'h0003, mode});
		repeat (5) @(negedge mclk);
		chk(instr_ready, 1'b0);
		chk(table_address_reg, p);
		// Latch already sampled in Q2, so disturbing it now must not matter
		table_byte_latch = ~lat;
		hold_raddr = slot;
		@(negedge mclk);
		chk(hold_rdata, 8'hFF);
		repeat (2) @(negedge mclk);
		chk(hold_rdata, lat);
		chk(table_address_reg, exp_ptr);
		chk(byte_sel_high, exp_ptr[0]);
		table_byte_latch = lat;
		$display("store mode %0d done", mode);
	endtask

	task automatic add(input logic [7:0] a, input logic [11:0] base, input logic [7:0] k,
		input logic d, input logic mode, input logic [7:0] b);
		logic [8:0] s9;
		logic [4:0] h;
		logic       apply;
		logic [4:0] got_flags;
		int         nwe;
		int         i;
		s9 = {1'b0, a} + {1'b0, b};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		apply = mode && (k <= 8'h5F);
		nwe = 0;
		acc_load = 1'b1;
		acc_wdata = a;
		@(negedge mclk);
		acc_load = 1'b0;
		index_base_reg = base;
		dmem_rdata = b;
		indexed_mode = mode;
		issue({6'h09, d, 1'b0, k});
		for (i = 0; i < 5; i++) begin
			@(negedge mclk);
			if (dmem_we === 1'b1) begin
				nwe++;
				chk(dmem_wdata, s9[7:0]);
			end
		end
		chk(24'(nwe), 24'(apply && d));
		if (apply) begin
			chk(dmem_addr, 12'(base + {4'h0, k}));
			exp_flags = {s9[7], a[7] == b[7] && s9[7] != a[7], s9[8], h[4], s9[7:0] == 8'h00};
		end
		chk(acc, (apply && !d) ? s9[7:0] : a);
		got_flags = {flag_neg, flag_signed_wrap, flag_carry, flag_half_carry, flag_zero};
		chk(got_flags, exp_flags);
		indexed_mode = 1'b1;
		$display("add k=%h d=%0d mode=%0d done", k, d, mode);
	endtask

	task automatic reset_values();
		int i;
		chk(instr_ready, 1'b1);
		chk(table_address_reg, 21'h000000);
		chk(acc, 8'h00);
		chk({flag_neg, flag_signed_wrap, flag_carry, flag_half_carry, flag_zero}, 5'h00);
		for (i = 0; i < 8; i++) begin
			hold_raddr = i[2:0];
			@(negedge mclk);
			chk(hold_rdata, 8'hFF);
		end
		$display("reset values done");
	endtask

	initial begin
		#20000;
		n_fail++;
		results();
	end

	initial begin
		arst_n = 1'b0;
		instr_valid = 1'b0;
		instr = 16'h0000;
		indexed_mode = 1'b1;
		table_byte_latch = 8'h00;
		ptr_load = 1'b0;
		ptr_wdata = 21'h000000;
		hold_raddr = 3'h0;
		index_base_reg = 12'h000;
		acc_load = 1'b0;
		acc_wdata = 8'h00;
		dmem_rdata = 8'h00;
		exp_flags = 5'h00;
		n_fail = 0;
		checks = 0;
		repeat (3) @(negedge mclk);
		arst_n = 1'b1;
		reset_values();
		store(2'h1, 21'h00A356, 8'h55, 21'h00A357, 3'h6);
		store(2'h3, 21'h01389A, 8'h34, 21'h01389B, 3'h3);
		hold_raddr = 3'h2;
		repeat (2) @(negedge mclk);
		chk(hold_rdata, 8'hFF);
		store(2'h2, 21'h000000, 8'hA5, 21'h1FFFFF, 3'h0);
		store(2'h0, 21'h000001, 8'h3C, 21'h000001, 3'h1);
		add(8'h17, 12'hA00, 8'h2C, 1'b0, 1'b1, 8'h20);
		add(8'h7F, 12'h010, 8'h5F, 1'b1, 1'b1, 8'h01);
		add(8'h80, 12'hFF0, 8'h00, 1'b0, 1'b1, 8'h80);
		add(8'h11, 12'h100, 8'h60, 1'b1, 1'b1, 8'h22);
		add(8'h11, 12'h100, 8'h05, 1'b0, 1'b0, 8'h22);
		results();
	end
endmodule

// ==== tsa_core.sv ====
// Execution logic for the table store and indexed add instructions
`timescale 1ns/10ps
`include "tsa_params.svh"

module tsa_core #(
	parameter int PTR_W  = `TSA_PTR_W,
	parameter int DEPTH  = `TSA_HOLD_DEPTH,
	parameter int SEL_W  = `TSA_SEL_W
) (
	input  wire logic                      mclk,
	input  wire logic                      arst_n,
	input  wire logic                      instr_valid,
	input  wire logic [`TSA_INSTR_W-1:0]   instr,
	output logic                           instr_ready,
	input  wire logic                      indexed_mode,
	input  wire logic [`TSA_DATA_W-1:0]    table_byte_latch,
	input  wire logic                      ptr_load,
	input  wire logic [PTR_W-1:0]          ptr_wdata,
	output logic      [PTR_W-1:0]          table_address_reg,
	input  wire logic [SEL_W-1:0]          hold_raddr,
	output logic      [`TSA_DATA_W-1:0]    hold_rdata,
	output logic                           byte_sel_high,
	input  wire logic [`TSA_DADDR_W-1:0]   index_base_reg,
	input  wire logic                      acc_load,
	input  wire logic [`TSA_DATA_W-1:0]    acc_wdata,
	output logic      [`TSA_DATA_W-1:0]    acc,
	output logic      [`TSA_DADDR_W-1:0]   dmem_addr,
	input  wire logic [`TSA_DATA_W-1:0]    dmem_rdata,
	output logic                           dmem_we,
	output logic      [`TSA_DATA_W-1:0]    dmem_wdata,
	output logic                           flag_neg,
	output logic                           flag_signed_wrap,
	output logic                           flag_carry,
	output logic                           flag_half_carry,
	output logic                           flag_zero
);

	initial begin
		if (PTR_W != `TSA_PTR_W || DEPTH != (1 << SEL_W) || SEL_W >= PTR_W)
			$error("tsa_core: pointer or holding register geometry not supported");
	end

	tsa_pkg::tsa_phase_t    phase, next_phase;
	tsa_pkg::tsa_state_t    st, next_st;
	tsa_pkg::tsa_ptr_mode_t mode, next_mode;
	logic                   dsel, next_dsel;
	logic [`TSA_DATA_W-1:0] tbl_byte, next_tbl_byte;
	logic [`TSA_DATA_W-1:0] operand, next_operand;
	logic [`TSA_DATA_W-1:0] sum, next_sum;
	logic                   sum_c, sum_hc, next_sum_c, next_sum_hc;
	logic [PTR_W-1:0]       next_ptr;
	logic [`TSA_DATA_W-1:0] next_acc;
	logic [`TSA_DADDR_W-1:0] next_dmem_addr;
	logic                   next_dmem_we;
	logic [`TSA_DATA_W-1:0] next_dmem_wdata;
	logic                   next_n, next_wrap, next_c, next_hc, next_z;
	logic                   hold_we;
	logic [SEL_W-1:0]       hold_waddr;
	logic                   is_tbl, is_add, accept;
	logic [`TSA_DATA_W:0]   wide_sum;
	logic [4:0]             low_sum;
	logic [PTR_W-1:0]       ptr_inc;

	assign instr_ready = (st == tsa_pkg::ST_FETCH) && (phase == tsa_pkg::PH_Q1);
	assign accept      = instr_ready && instr_valid;
	assign is_tbl      = (instr[15:2] == `TSA_TBL_OPC);
	// Offset form is only recognised in indexed mode and with k inside 0..95
	assign is_add      = indexed_mode && (instr[15:10] == `TSA_ADD_OPC)
		&& !instr[`TSA_ADD_ZERO_BIT] && (instr[7:0] <= `TSA_K_MAX);
	assign ptr_inc     = table_address_reg + PTR_W'(1);
	assign byte_sel_high = table_address_reg[0];

	// Pre-increment stores at the new pointer, every other variant at the old one
	assign hold_we    = (st == tsa_pkg::ST_TBL_XFER) && (phase == tsa_pkg::PH_Q4);
	assign hold_waddr = (mode == tsa_pkg::PM_PRE_INC) ? ptr_inc[SEL_W-1:0]
		: table_address_reg[SEL_W-1:0];

	// Only a staging store; the flash programming sequence reads it out later
	tsa_hold_mem #(
		.WIDTH (`TSA_DATA_W),
		.DEPTH (DEPTH),
		.AW    (SEL_W)
	) u_hold (
		.mclk   (mclk),
		.arst_n (arst_n),
		.we     (hold_we),
		.waddr  (hold_waddr),
		.wdata  (tbl_byte),
		.raddr  (hold_raddr),
		.rdata  (hold_rdata)
	);

	always_comb begin
		next_phase      = tsa_pkg::tsa_phase_t'(phase + 2'h1);
		next_st         = st;
		next_mode       = mode;
		next_dsel       = dsel;
		next_tbl_byte   = tbl_byte;
		next_operand    = operand;
		next_sum        = sum;
		next_sum_c      = sum_c;
		next_sum_hc     = sum_hc;
		next_ptr        = table_address_reg;
		next_acc        = acc;
		next_dmem_addr  = dmem_addr;
		next_dmem_we    = 1'b0;
		next_dmem_wdata = dmem_wdata;
		next_n          = flag_neg;
		next_wrap       = flag_signed_wrap;
		next_c          = flag_carry;
		next_hc         = flag_half_carry;
		next_z          = flag_zero;
		wide_sum        = {1'b0, acc} + {1'b0, operand};
		low_sum         = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
		if (acc_load) begin
			next_acc = acc_wdata;
		end
		unique case (st)
			tsa_pkg::ST_FETCH: begin
				if (accept && is_tbl) begin
					next_st   = tsa_pkg::ST_TBL_DEC;
					next_mode = tsa_pkg::tsa_ptr_mode_t'(instr[1:0]);
				end else if (accept && is_add) begin
					next_st        = tsa_pkg::ST_ADD;
					next_dsel      = instr[`TSA_ADD_D_BIT];
					next_dmem_addr = `TSA_DADDR_W'(index_base_reg + {4'h0, instr[7:0]});
				end
			end
			tsa_pkg::ST_ADD: begin
				if (phase == tsa_pkg::PH_Q2) begin
					next_operand = dmem_rdata;
				end
				if (phase == tsa_pkg::PH_Q3) begin
					next_sum        = wide_sum[`TSA_DATA_W-1:0];
					next_sum_c      = wide_sum[`TSA_DATA_W];
					next_sum_hc     = low_sum[4];
					next_dmem_we    = dsel;
					next_dmem_wdata = wide_sum[`TSA_DATA_W-1:0];
				end
				if (phase == tsa_pkg::PH_Q4) begin
					next_st = tsa_pkg::ST_FETCH;
					if (!dsel) begin
						next_acc = sum;
					end
					next_n  = sum[7];
					next_wrap = (acc[7] == operand[7]) && (sum[7] != acc[7]);
					next_c    = sum_c;
					next_hc   = sum_hc;
					next_z  = (sum == `TSA_DATA_W'(0));
				end
			end
			tsa_pkg::ST_TBL_DEC: begin
				if (phase == tsa_pkg::PH_Q4) begin
					next_st = tsa_pkg::ST_TBL_XFER;
				end
			end
			tsa_pkg::ST_TBL_XFER: begin
				if (phase == tsa_pkg::PH_Q2) begin
					next_tbl_byte = table_byte_latch;
				end
				if (phase == tsa_pkg::PH_Q4) begin
					next_st = tsa_pkg::ST_FETCH;
					unique case (mode)
						tsa_pkg::PM_KEEP:     next_ptr = table_address_reg;
						tsa_pkg::PM_POST_INC: next_ptr = ptr_inc;
						tsa_pkg::PM_POST_DEC: next_ptr = table_address_reg - PTR_W'(1);
						tsa_pkg::PM_PRE_INC:  next_ptr = ptr_inc;
					endcase
				end
			end
		endcase
		// A pointer load from outside wins over the store's own pointer step
		if (ptr_load) begin
			next_ptr = ptr_wdata;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			phase             <= tsa_pkg::PH_Q1;
			st                <= tsa_pkg::ST_FETCH;
			mode              <= tsa_pkg::PM_KEEP;
			dsel              <= 1'b1;
			tbl_byte          <= `TSA_ACC_RST;
			operand           <= `TSA_ACC_RST;
			sum               <= `TSA_ACC_RST;
			sum_c             <= 1'b0;
			sum_hc            <= 1'b0;
			table_address_reg <= `TSA_PTR_RST;
			acc               <= `TSA_ACC_RST;
			dmem_addr         <= `TSA_DADDR_RST;
			dmem_we           <= 1'b0;
			dmem_wdata        <= `TSA_ACC_RST;
			flag_neg          <= 1'b0;
			flag_signed_wrap  <= 1'b0;
			flag_carry        <= 1'b0;
			flag_half_carry   <= 1'b0;
			flag_zero         <= 1'b0;
		end else begin
			phase             <= next_phase;
			st                <= next_st;
			mode              <= next_mode;
			dsel              <= next_dsel;
			tbl_byte          <= next_tbl_byte;
			operand           <= next_operand;
			sum               <= next_sum;
			sum_c             <= next_sum_c;
			sum_hc            <= next_sum_hc;
			table_address_reg <= next_ptr;
			acc               <= next_acc;
			dmem_addr         <= next_dmem_addr;
			dmem_we           <= next_dmem_we;
			dmem_wdata        <= next_dmem_wdata;
			flag_neg          <= next_n;
			flag_signed_wrap  <= next_wrap;
			flag_carry        <= next_c;
			flag_half_carry   <= next_hc;
			flag_zero         <= next_z;
		end
	end

	sequence s_tbl_busy;
		!instr_ready [*7] ##1 instr_ready;
	endsequence

	property p_tbl_two_cycles;
		@(posedge mclk) disable iff (!arst_n)
		accept && is_tbl |=> s_tbl_busy;
	endproperty
	a_tbl_two_cycles: assert property (p_tbl_two_cycles)
		else $error("table store did not take two instruction cycles");

	property p_hold_at_q4;
		@(posedge mclk) disable iff (!arst_n)
		accept && is_tbl |-> ##7 hold_we ##1 !hold_we;
	endproperty
	a_hold_at_q4: assert property (p_hold_at_q4)
		else $error("holding register not written in Q4 of second cycle");

	property p_sel_old_ptr;
		@(posedge mclk) disable iff (!arst_n)
		hold_we && mode != tsa_pkg::PM_PRE_INC |=>
			u_hold.mem[$past(table_address_reg[SEL_W-1:0])] == $past(tbl_byte);
	endproperty
	a_sel_old_ptr: assert property (p_sel_old_ptr)
		else $error("latch byte not stored at low pointer bits");

	property p_pre_inc;
		@(posedge mclk) disable iff (!arst_n)
		hold_we && mode == tsa_pkg::PM_PRE_INC && !ptr_load |=>
			u_hold.mem[table_address_reg[SEL_W-1:0]] == $past(tbl_byte)
			&& table_address_reg == $past(table_address_reg) + PTR_W'(1);
	endproperty
	a_pre_inc: assert property (p_pre_inc)
		else $error("pre-increment store used wrong slot or pointer");

	property p_post_step;
		@(posedge mclk) disable iff (!arst_n)
		hold_we && !ptr_load |=> table_address_reg ==
			($past(mode) == tsa_pkg::PM_POST_INC ? $past(ptr_inc) :
			 $past(mode) == tsa_pkg::PM_POST_DEC ? $past(table_address_reg) - PTR_W'(1) :
			 $past(mode) == tsa_pkg::PM_KEEP ? $past(table_address_reg) : $past(ptr_inc));
	endproperty
	a_post_step: assert property (p_post_step)
		else $error("pointer variant moved pointer wrongly");

	property p_add_addr;
		@(posedge mclk) disable iff (!arst_n)
		accept && is_add |=> dmem_addr == `TSA_DADDR_W'($past(index_base_reg)
			+ {4'h0, $past(instr[7:0])});
	endproperty
	a_add_addr: assert property (p_add_addr)
		else $error("indexed add formed wrong operand address");

	property p_add_to_acc;
		@(posedge mclk) disable iff (!arst_n)
		accept && is_add && !instr[`TSA_ADD_D_BIT] && !acc_load ##1 !acc_load [*3]
			|=> acc == `TSA_DATA_W'($past(acc, 4) + $past(dmem_rdata, 3)) && !$past(dmem_we);
	endproperty
	a_add_to_acc: assert property (p_add_to_acc)
		else $error("sum not routed to accumulator");

	property p_add_flags;
		@(posedge mclk) disable iff (!arst_n)
		st == tsa_pkg::ST_ADD && phase == tsa_pkg::PH_Q4 |=>
			flag_zero == ($past(sum) == `TSA_DATA_W'(0)) && flag_neg == $past(sum[7])
			&& flag_carry == $past(sum_c);
	endproperty
	a_add_flags: assert property (p_add_flags)
		else $error("add flags not updated from sum");

	property p_add_to_reg;
		@(posedge mclk) disable iff (!arst_n)
		dmem_we |-> dsel && phase == tsa_pkg::PH_Q4 && dmem_wdata == sum;
	endproperty
	a_add_to_reg: assert property (p_add_to_reg)
		else $error("register write-back out of phase or wrong data");

endmodule

// ==== tsa_hold_mem.sv ====
// Program-memory holding registers with a registered read port
`timescale 1ns/10ps
module tsa_hold_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem      [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [WIDTH-1:0] next_rdata;

	initial begin
		if (DEPTH != (1 << AW) || WIDTH < 1)
			$error("tsa_hold_mem: DEPTH must equal 2**AW");
	end

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			next_mem[i] = mem[i];
		end
		if (we) begin
			next_mem[waddr] = wdata;
		end
		next_rdata = mem[raddr];
	end

	// Erased state reads as all ones, as flash does after an erase
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= `TSA_HOLD_RST;
			end
			rdata <= `TSA_HOLD_RST;
		end else begin
			mem   <= next_mem;
			rdata <= next_rdata;
		end
	end

endmodule

// ==== tsa_params.svh ====
// Constants for the table store and indexed add execution block
`ifndef TSA_PARAMS_SVH
`define TSA_PARAMS_SVH

`define TSA_PTR_W        21
`define TSA_PTR_RST      21'h000000
`define TSA_SEL_W        3
`define TSA_HOLD_DEPTH   8
`define TSA_HOLD_RST     8'hFF
`define TSA_DATA_W       8
`define TSA_DADDR_W      12
`define TSA_INSTR_W      16
`define TSA_TBL_OPC      14'h0003
`define TSA_ADD_OPC      6'h09
`define TSA_ADD_D_BIT    9
`define TSA_ADD_ZERO_BIT 8
`define TSA_K_MAX        8'h5F
`define TSA_ACC_RST      8'h00
`define TSA_DADDR_RST    12'h000

`endif

// ==== tsa_pkg.sv ====
// Types shared by the table store and indexed add execution block
package tsa_pkg;

	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} tsa_phase_t;

	typedef enum logic [1:0] {
		PM_KEEP = 2'h0,
		PM_POST_INC = 2'h1,
		PM_POST_DEC = 2'h2,
		PM_PRE_INC = 2'h3
	} tsa_ptr_mode_t;

	typedef enum logic [1:0] {
		ST_FETCH,
		ST_ADD,
		ST_TBL_DEC,
		ST_TBL_XFER
	} tsa_state_t;

endpackage
